// >>> common/emc_pkg.sv
package emc_pkg;
    // Register byte offsets
    localparam logic [7:0] CLOCK_CONFIG_REG_OFF = 8'h00;
    localparam logic [7:0] TIMER_OUTPUT_CTRL_OFF = 8'h04;
    localparam logic [7:0] KEYPAD_FLAG_REG_OFF = 8'h08;
    localparam logic [7:0] KEYPAD_EDGE_MODE_OFF = 8'h0C;
    localparam logic [7:0] PORT_MODE_OFF = 8'h10;
    localparam logic [7:0] SERIAL_CTRL_OFF = 8'h14;
    localparam logic [7:0] STATUS_OFF = 8'h18;
    localparam logic [7:0] FETCH_CHECK_OFF = 8'h1C;
    // clock_config_reg fields
    localparam int PRESCALE_LSB = 4;
    localparam int DBL_BIT = 3;
    localparam int SRC_LSB = 0;
    localparam int RELOAD_LSB = 8;
    // Reset values
    localparam logic [3:0] PRESCALE_RST_COMPAT = 4'h5;
    localparam logic [3:0] PRESCALE_RST_FAST = 4'h0;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    // Oscillator divider reset divisors
    localparam logic [1:0] OSC_DIV_COMPAT = 2'h2;
    localparam logic [1:0] OSC_DIV_FAST = 2'h1;
    // Cadence counts in system clocks
    localparam logic [1:0] FETCH_COMPAT = 2'h3;
    localparam logic [1:0] FETCH_FAST = 2'h1;
    localparam logic [4:0] CYC_COMPAT = 5'h06;
    localparam logic [4:0] CYC_FAST = 5'h01;
    localparam logic [3:0] RST_MIN_COMPAT = 4'hC;
    localparam logic [3:0] RST_MIN_FAST = 4'h2;
    // Program memory limits
    localparam logic [15:0] INT_CODE_TOP = 16'h1FFF;
    // Clock sources
    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'h0,
        SRC_EXTCLK = 2'h1,
        SRC_RC8M = 2'h2
    } emc_src_type;
    // Port modes
    localparam logic [1:0] PM_QUASI = 2'h0;
    localparam logic [1:0] PM_PUSHPULL = 2'h1;
    localparam logic [1:0] PM_INPUT = 2'h2;
    localparam logic [1:0] PM_OPENDRAIN = 2'h3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : emc_pkg

// >>> hdl/emc_top.sv
`timescale 1ns/1ns
// How it works
// R1: fetch strobe every 3 or 1 clocks
// R2: instruction spans 6-24 or 1-5 clocks
// R3: oscillator divider defaults 2 compat, 1 fast
// R4: double speed bypasses halving; reload divides more
// R5: source select crystal, external, RC; secondary too
// R6: pins sampled at prescaler or system rate
// R7: reset recognised after 12 or 2 clocks
// R8: polarity pin sets reset pin active level
// R9: shared prescaler; select resets 0101 or 0000
// R10: select gives rate full down to 1/16
// R11: timer2 clockout/baud modes bypass prescaler
// R12: overflow toggles timer pin when enabled
// R13: flag read keeps bits; clear per bit
// R14: edge mode selects edge-triggered keypad interrupts
// R15: tristate fuse picks port defaults
// R16: port 4 always quasi-bidirectional
// R17: port 0 pull-ups in quasi or output
// R18: no external fetch low; lock blocks above
// R19: shift mode polarity, phase, rate, full duplex
// R20: mode fuse captured at reset, then held
module emc_top
    import emc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Fuses and pins
    input wire logic compat_fuse_in,
    input wire logic tristate_fuse_in,
    input wire logic lock3_in,
    input wire logic reset_polarity_select_in,
    input wire logic reset_pin_in,
    input wire logic [5:0] ext_pins_in,
    input wire logic [1:0] timer_ovf_in,
    input wire logic timer2_bypass_in,
    input wire logic [7:0] keypad_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic fetch_ext_in,
    // Core timing
    output logic fetch_strobe_out,
    output logic instr_done_out,
    input wire logic [2:0] instr_len_in,
    output logic sys_en_out,
    output logic [1:0] clk_source_out,
    output logic secondary_oscillator_out,
    output logic prescale_tick_out,
    output logic timer2_tick_out,
    output logic [5:0] ext_pins_sampled_out,
    output logic reset_req_out,
    output logic [1:0] timer_pin_out,
    output logic keypad_irq_out,
    output logic [9:0] port_mode_out,
    output logic port0_pullup_out,
    output logic ext_fetch_ok_out,
    output logic [3:0] serial_ctrl_out,
    output logic fast_mode_out,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic mode_taken;
    logic fast;
    logic [3:0] timer_prescale_select;
    logic double_speed_clock;
    logic [1:0] src_sel;
    logic secondary_oscillator;
    logic [7:0] clock_reload_divider;
    logic [1:0] timer_output_ctrl;
    logic [7:0] keypad_flag_reg;
    logic [7:0] keypad_edge_mode;
    logic [9:0] port_mode;
    logic [3:0] serial_ctrl;
    logic [7:0] osc_cnt;
    logic [3:0] pre_cnt;
    logic [1:0] fetch_cnt;
    logic [4:0] cyc_cnt;
    logic [2:0] instr_cnt;
    logic [3:0] rst_cnt;
    logic [5:0] pin_s1, pin_s2, pin_smp;
    logic [7:0] key_s1, key_s2, key_d;
    logic rp_s1, rp_s2, psel_s1, psel_s2;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go, clr_fire;
    logic [7:0] key_clr, key_set;
    logic [7:0] next_div;
    logic reset_active;

    // Mode fuse caught after release, then frozen
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_taken <= 1'b0;
            fast <= 1'b0;
        end else if (!mode_taken) begin
            mode_taken <= 1'b1;
            fast <= ~compat_fuse_in; // [R20]
        end
    end
    assign fast_mode_out = fast;

    // AXI write channel capture
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
    assign s_axi_bresp = (aw_addr[7:5] == 3'h0 && aw_addr[1:0] == 2'h0)
        ? RESP_OKAY : RESP_SLVERR;

    // Control registers; defaults follow the mode fuse, port defaults the tristate fuse
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_prescale_select <= PRESCALE_RST_COMPAT;
            double_speed_clock <= 1'b0;
            src_sel <= SRC_CRYSTAL;
            secondary_oscillator <= 1'b0;
            clock_reload_divider <= RELOAD_RST;
            timer_output_ctrl <= 2'h0;
            keypad_edge_mode <= 8'h00;
            port_mode <= 10'h000;
            serial_ctrl <= 4'h0;
        end else if (!mode_taken) begin
            // Fast mode: no halving, prescale at clock rate
            timer_prescale_select <= compat_fuse_in ? PRESCALE_RST_COMPAT
                : PRESCALE_RST_FAST; // [R9]
            double_speed_clock <= ~compat_fuse_in; // [R3]
            port_mode[7:0] <= tristate_fuse_in ? {4{PM_INPUT}} // [R15]
                : {PM_QUASI, PM_QUASI, PM_QUASI, PM_OPENDRAIN};
        end else if (wr_go && w_strb[0]) begin
            unique case (aw_addr)
                CLOCK_CONFIG_REG_OFF: begin
                    timer_prescale_select <= w_data[PRESCALE_LSB +: 4];
                    double_speed_clock <= w_data[DBL_BIT]; // [R4]
                    if (w_data[SRC_LSB +: 2] != 2'h3) begin
                        src_sel <= w_data[SRC_LSB +: 2]; // [R5]
                    end
                    secondary_oscillator <= w_data[2];
                    if (w_strb[1]) begin
                        clock_reload_divider <= w_data[RELOAD_LSB +: 8];
                    end
                end
                TIMER_OUTPUT_CTRL_OFF: timer_output_ctrl <= w_data[1:0];
                KEYPAD_EDGE_MODE_OFF: keypad_edge_mode <= w_data[7:0];
                // Port 4 field never leaves quasi, so writes skip it
                PORT_MODE_OFF: port_mode[7:0] <= w_data[7:0]; // [R16]
                SERIAL_CTRL_OFF: serial_ctrl <= w_data[3:0]; // [R19]
                default: ;
            endcase
        end
    end
    assign clk_source_out = src_sel;
    assign secondary_oscillator_out = secondary_oscillator;
    assign port_mode_out = port_mode;
    assign serial_ctrl_out = serial_ctrl;
    // Port 0 pull-ups only where the pin may drive high
    assign port0_pullup_out = (port_mode[1:0] == PM_QUASI)
        || (port_mode[1:0] == PM_PUSHPULL); // [R17]

    // Oscillator divider: halving unless double speed, then reload
    // The same divider serves either oscillator
    always_comb begin
        next_div = clock_reload_divider;
        if (!double_speed_clock) begin
            next_div = {clock_reload_divider[6:0], 1'b1}; // [R4] [R5]
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_cnt <= 8'h00;
        end else if (osc_cnt >= next_div) begin
            osc_cnt <= 8'h00; // [R3]
        end else begin
            osc_cnt <= osc_cnt + 8'h01;
        end
    end
    assign sys_en_out = (osc_cnt >= next_div);

    // Fetch and instruction cadence, counted in system clocks
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fetch_cnt <= 2'h0;
            cyc_cnt <= 5'h00;
            instr_cnt <= 3'h0;
        end else if (sys_en_out) begin
            if (fetch_cnt + 2'h1 >= (fast ? FETCH_FAST : FETCH_COMPAT)) begin
                fetch_cnt <= 2'h0; // [R1]
            end else begin
                fetch_cnt <= fetch_cnt + 2'h1;
            end
            if (cyc_cnt + 5'h01 >= (fast ? CYC_FAST : CYC_COMPAT)) begin
                cyc_cnt <= 5'h00;
                // Compat counts machine cycles of six, lengths 1..4
                if (instr_done_out) begin
                    instr_cnt <= 3'h0; // [R2]
                end else begin
                    instr_cnt <= instr_cnt + 3'h1;
                end
            end else begin
                cyc_cnt <= cyc_cnt + 5'h01;
            end
        end
    end
    assign fetch_strobe_out = sys_en_out && fetch_cnt == 2'h0;
    assign instr_done_out = sys_en_out
        && (cyc_cnt + 5'h01 >= (fast ? CYC_FAST : CYC_COMPAT))
        && (instr_cnt + 3'h1 >= (instr_len_in == 3'h0 ? 3'h1 : instr_len_in));

    // Shared prescaler: tick every select+1 system clocks
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_cnt <= 4'h0;
        end else if (sys_en_out) begin
            if (pre_cnt >= timer_prescale_select) begin
                pre_cnt <= 4'h0; // [R10]
            end else begin
                pre_cnt <= pre_cnt + 4'h1;
            end
        end
    end
    assign prescale_tick_out = sys_en_out && pre_cnt >= timer_prescale_select;
    assign timer2_tick_out = timer2_bypass_in ? sys_en_out
        : prescale_tick_out; // [R11]

    // Pin synchronisers and rate sampling
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
            pin_smp <= 6'h00;
        end else begin
            pin_s1 <= ext_pins_in;
            pin_s2 <= pin_s1;
            if (fast ? sys_en_out : prescale_tick_out) begin
                pin_smp <= pin_s2; // [R6]
            end
        end
    end
    assign ext_pins_sampled_out = pin_smp;

    // Reset pin: polarity and minimum width
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rp_s1 <= 1'b0;
            rp_s2 <= 1'b0;
            psel_s1 <= 1'b0;
            psel_s2 <= 1'b0;
        end else begin
            rp_s1 <= reset_pin_in;
            rp_s2 <= rp_s1;
            psel_s1 <= reset_polarity_select_in;
            psel_s2 <= psel_s1;
        end
    end
    assign reset_active = psel_s2 ? rp_s2 : !rp_s2; // [R8]
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_cnt <= 4'h0;
        end else if (!reset_active || !mode_taken) begin
            rst_cnt <= 4'h0;
        end else if (sys_en_out && !reset_req_out) begin
            rst_cnt <= rst_cnt + 4'h1; // [R7]
        end
    end
    assign reset_req_out = rst_cnt >= (fast ? RST_MIN_FAST : RST_MIN_COMPAT);

    // Overflow toggles the counter pin
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_pin_out <= 2'h0;
        end else begin
            timer_pin_out <= timer_pin_out
                ^ (timer_ovf_in & timer_output_ctrl); // [R12]
        end
    end

    // Keypad: level or edge per bit; set beats clear; reads keep
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            key_s1 <= 8'h00;
            key_s2 <= 8'h00;
            key_d <= 8'h00;
        end else begin
            key_s1 <= keypad_in;
            key_s2 <= key_s1;
            key_d <= key_s2;
        end
    end
    assign key_set = keypad_edge_mode & (key_s2 & ~key_d)
        | ~keypad_edge_mode & key_s2; // [R14]
    assign clr_fire = wr_go && w_strb[0] && aw_addr == KEYPAD_FLAG_REG_OFF;
    assign key_clr = clr_fire ? w_data[7:0] : 8'h00;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            keypad_flag_reg <= 8'h00;
        end else begin
            keypad_flag_reg <= (keypad_flag_reg & ~key_clr) | key_set; // [R13]
        end
    end
    assign keypad_irq_out = |keypad_flag_reg;

    // External fetch gate
    assign ext_fetch_ok_out = fetch_ext_in && fetch_addr_in > INT_CODE_TOP
        && !lock3_in; // [R18]

    // AXI read channel
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                CLOCK_CONFIG_REG_OFF: s_axi_rdata <= {16'h0000,
                    clock_reload_divider, timer_prescale_select,
                    double_speed_clock, secondary_oscillator, src_sel};
                TIMER_OUTPUT_CTRL_OFF: s_axi_rdata <= {30'h0, timer_output_ctrl};
                KEYPAD_FLAG_REG_OFF: s_axi_rdata <= {24'h0, keypad_flag_reg};
                KEYPAD_EDGE_MODE_OFF: s_axi_rdata <= {24'h0, keypad_edge_mode};
                PORT_MODE_OFF: s_axi_rdata <= {22'h0, port_mode};
                SERIAL_CTRL_OFF: s_axi_rdata <= {28'h0, serial_ctrl};
                STATUS_OFF: s_axi_rdata <= {27'h0, reset_req_out,
                    timer_pin_out, port0_pullup_out, fast};
                FETCH_CHECK_OFF: s_axi_rdata <= {31'h0, lock3_in};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    // Checks
    property p_fetch_fast;
        @(posedge mclk_in) disable iff (!rst_n_in)
        fast && sys_en_out && mode_taken |-> fetch_strobe_out;
    endproperty
    a_fetch_fast: assert property (p_fetch_fast) // [R1]
        else $error("fast fetch missed");
    property p_fetch_gap;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !fast && fetch_strobe_out && double_speed_clock
            |=> !fetch_strobe_out;
    endproperty
    a_fetch_gap: assert property (p_fetch_gap) // [R1]
        else $error("compat fetch too soon");
    property p_presc_default;
        @(posedge mclk_in) disable iff (!rst_n_in)
        $rose(mode_taken) |-> timer_prescale_select
            == (fast ? PRESCALE_RST_FAST : PRESCALE_RST_COMPAT);
    endproperty
    a_presc_default: assert property (p_presc_default) // [R9]
        else $error("prescale default wrong");
    property p_mode_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        mode_taken |=> $stable(fast);
    endproperty
    a_mode_hold: assert property (p_mode_hold) // [R20]
        else $error("mode changed");
    property p_key_keep;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !clr_fire |=> (keypad_flag_reg & $past(keypad_flag_reg))
            == $past(keypad_flag_reg);
    endproperty
    a_key_keep: assert property (p_key_keep) // [R13]
        else $error("keypad flag lost");
    property p_toggle;
        @(posedge mclk_in) disable iff (!rst_n_in)
        timer_ovf_in[0] && timer_output_ctrl[0]
            |=> timer_pin_out[0] != $past(timer_pin_out[0]);
    endproperty
    a_toggle: assert property (p_toggle) // [R12]
        else $error("timer pin no toggle");
    property p_no_low_fetch;
        @(posedge mclk_in) disable iff (!rst_n_in)
        fetch_addr_in <= INT_CODE_TOP || lock3_in |-> !ext_fetch_ok_out;
    endproperty
    a_no_low_fetch: assert property (p_no_low_fetch) // [R18]
        else $error("external fetch allowed");
    property p_timer2_bypass;
        @(posedge mclk_in) disable iff (!rst_n_in)
        timer2_bypass_in |-> timer2_tick_out == sys_en_out;
    endproperty
    a_timer2_bypass: assert property (p_timer2_bypass) // [R11]
        else $error("timer2 prescaled");
    property p_pullup;
        @(posedge mclk_in) disable iff (!rst_n_in)
        port_mode[1:0] == PM_OPENDRAIN |-> !port0_pullup_out;
    endproperty
    a_pullup: assert property (p_pullup) // [R17]
        else $error("port0 pullup in open drain");
endmodule : emc_top

// >>> dv/emc_tb.sv
`timescale 1ns/1ns
module tb;
    import emc_pkg::*;
    logic mclk_in = 1'b0, rst_n_in = 1'b0, compat_fuse_in = 1'b1;
    logic tristate_fuse_in = 1'b1, lock3_in = 1'b0, fetch_ext_in = 1'b0;
    logic reset_polarity_select_in = 1'b1, reset_pin_in = 1'b0;
    logic timer2_bypass_in = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [5:0] ext_pins_in = 6'h00;
    logic [1:0] timer_ovf_in = 2'h0;
    logic [7:0] keypad_in = 8'h00, s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [15:0] fetch_addr_in = 16'h0000;
    logic [2:0] instr_len_in = 3'h1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, serial_ctrl_out;
    logic fetch_strobe_out, instr_done_out, sys_en_out, prescale_tick_out;
    logic secondary_oscillator_out, timer2_tick_out, reset_req_out;
    logic keypad_irq_out, port0_pullup_out, ext_fetch_ok_out, fast_mode_out;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] clk_source_out, timer_pin_out, s_axi_bresp, s_axi_rresp;
    logic [5:0] ext_pins_sampled_out;
    logic [9:0] port_mode_out;
    logic [31:0] rd;
    logic [1:0] resp;
    logic [1:0] pin_was;
    int num_errors = 0, samples_checked = 0, n, m, len;

    emc_top dut (.*);

    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    task summarize();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task axi_write(input logic [7:0] addr, input logic [31:0] data);
        logic aw_done, w_done;
        // An edge apart, so a ready never drops and rises in one step
        @(posedge mclk_in);
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge mclk_in);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk_in); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [7:0] addr);
        @(posedge mclk_in);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk_in); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk_in); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    function automatic logic pulse(input int sel);
        case (sel)
            0: return sys_en_out;
            1: return fetch_strobe_out;
            2: return instr_done_out;
            3: return prescale_tick_out;
            default: return timer2_tick_out;
        endcase
    endfunction : pulse

    // Sel 0 counts clocks, others count system enables between pulses
    task gap(input int sel);
        do @(posedge mclk_in); while (pulse(sel) !== 1'b1);
        n = 0;
        do begin
            @(posedge mclk_in);
            n += (sel == 0) ? 1 : int'(sys_en_out === 1'b1);
        end while (pulse(sel) !== 1'b1);
    endtask : gap

    // A change of length takes effect at once, so the running instruction may end early or late
    task gap2(input int sel);
        gap(sel);
        gap(sel);
    endtask : gap2

    initial begin
        #400000;
        num_errors++;
        summarize();
    end

    initial begin
        for (m = 1; m >= 0; m--) begin
            rst_n_in <= 1'b0;
            compat_fuse_in <= m[0];
            tristate_fuse_in <= m[0];
            repeat (12) @(posedge mclk_in);
            rst_n_in <= 1'b1;
            repeat (3) @(posedge mclk_in);
            check(fast_mode_out, !m[0]);
            axi_read(CLOCK_CONFIG_REG_OFF);
            check(rd[15:4], m ? 12'h005 : 12'h000);
            axi_read(STATUS_OFF);
            check(rd[0], !m[0]);
            gap2(0);
            check(n, m ? 2 : 1);
            gap2(1);
            check(n, m ? 3 : 1);
            for (len = 1; len <= (m ? 4 : 5); len++) begin
                instr_len_in <= len[2:0];
                gap2(2);
                check(n, m ? 6 * len : len);
            end
            gap2(3);
            check(n, m ? 6 : 1);
            axi_write(CLOCK_CONFIG_REG_OFF, 32'h000000FE);
            check(resp, RESP_OKAY);
            gap2(0);
            check(n, 1);
            gap2(3);
            check(n, 16);
            timer2_bypass_in <= 1'b1;
            gap2(4);
            check(n, 1);
            timer2_bypass_in <= 1'b0;
            gap2(4);
            check(n, 16);
            check(clk_source_out, SRC_RC8M);
            check(secondary_oscillator_out, 1'b1);
            // Pins only settle after the sync stages and a prescaler tick (compat) or a system enable (fast)
            ext_pins_in <= 6'h2A;
            repeat (80) @(posedge mclk_in);
            check(ext_pins_sampled_out, 6'h2A);
            ext_pins_in <= 6'h00;
            check(port_mode_out[7:0], m ? 8'hAA : 8'h03);
            check(port_mode_out[9:8], PM_QUASI);
            check(port0_pullup_out, 1'b0);
            axi_write(PORT_MODE_OFF, {30'h0, PM_QUASI});
            repeat (2) @(posedge mclk_in);
            check(port0_pullup_out, 1'b1);
            axi_write(PORT_MODE_OFF, {22'h0, 2'h3, 6'h00, PM_PUSHPULL});
            repeat (2) @(posedge mclk_in);
            check(port0_pullup_out, 1'b1);
            check(port_mode_out[9:8], PM_QUASI);
            axi_write(TIMER_OUTPUT_CTRL_OFF, 32'h1);
            pin_was = timer_pin_out;
            timer_ovf_in <= 2'h3;
            @(posedge mclk_in);
            timer_ovf_in <= 2'h0;
            repeat (3) @(posedge mclk_in);
            check(timer_pin_out, {pin_was[1], ~pin_was[0]});
            axi_write(KEYPAD_EDGE_MODE_OFF, 32'hFF);
            keypad_in <= 8'h03;
            repeat (6) @(posedge mclk_in);
            keypad_in <= 8'h00;
            repeat (6) @(posedge mclk_in);
            axi_read(KEYPAD_FLAG_REG_OFF);
            check(rd[7:0], 8'h03);
            axi_read(KEYPAD_FLAG_REG_OFF);
            check(rd[7:0], 8'h03);
            axi_write(KEYPAD_FLAG_REG_OFF, 32'h1);
            axi_read(KEYPAD_FLAG_REG_OFF);
            check(rd[7:0], 8'h02);
            check(keypad_irq_out, 1'b1);
            axi_write(KEYPAD_FLAG_REG_OFF, 32'h2);
            repeat (2) @(posedge mclk_in);
            check(keypad_irq_out, 1'b0);
            fetch_ext_in <= 1'b1;
            fetch_addr_in <= INT_CODE_TOP;
            @(posedge mclk_in);
            #1 check(ext_fetch_ok_out, 1'b0);
            @(posedge mclk_in);
            fetch_addr_in <= INT_CODE_TOP + 16'h0001;
            @(posedge mclk_in);
            #1 check(ext_fetch_ok_out, 1'b1);
            @(posedge mclk_in);
            lock3_in <= 1'b1;
            @(posedge mclk_in);
            #1 check(ext_fetch_ok_out, 1'b0);
            @(posedge mclk_in);
            lock3_in <= 1'b0;
            fetch_ext_in <= 1'b0;
            axi_read(8'h40);
            check(resp, RESP_SLVERR);
            axi_write(8'h40, 32'h0);
            check(resp, RESP_SLVERR);
            axi_write(SERIAL_CTRL_OFF, 32'hA);
            check(serial_ctrl_out, 4'hA);
            compat_fuse_in <= !m[0];
            repeat (4) @(posedge mclk_in);
            check(fast_mode_out, !m[0]);
            // A one-clock glitch is too short to count as reset
            reset_pin_in <= 1'b1;
            @(posedge mclk_in);
            reset_pin_in <= 1'b0;
            repeat (10) @(posedge mclk_in);
            check(reset_req_out, 1'b0);
            reset_polarity_select_in <= 1'b0;
            repeat (60) @(posedge mclk_in);
            check(reset_req_out, 1'b1);
            reset_polarity_select_in <= 1'b1;
            repeat (10) @(posedge mclk_in);
            check(reset_req_out, 1'b0);
        end
        summarize();
    end
endmodule : tb
